// file: voice_store_pkg.sv
// constants, field layout and state types of the voice store command block
package voice_store_pkg;

	// clock and sample rates
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned SAMPLE_HZ     = 8_000;
	localparam int unsigned EXT_CLK_HZ    = 1_024_000;
	localparam int unsigned EXT_CLK_DIV   = 2;
	localparam int unsigned BASE_PER_SMP  = 2;
	localparam int unsigned INT_BASE_DIV  = CLK_HZ / (SAMPLE_HZ * BASE_PER_SMP);
	localparam int unsigned EXT_BASE_DIV  = EXT_CLK_HZ / EXT_CLK_DIV / (SAMPLE_HZ * BASE_PER_SMP);

	// wake delay after power-up, in microseconds and in clock cycles
	localparam int unsigned WAKE_DELAY_US = 25_000;
	localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
	localparam int unsigned WAKE_CYCLES   = WAKE_DELAY_US * CLK_PER_US;

	// frame layout: address bits first, then control bits, lsb first
	localparam int unsigned FRAME_BITS    = 16;
	localparam int unsigned ADDR_BITS     = 11;
	localparam int unsigned ROW_BITS      = 10;
	localparam int unsigned CTRL_BITS     = 5;
	localparam int unsigned ADDR_LSB      = 0;
	localparam int unsigned CTRL_LSB      = ADDR_LSB + ADDR_BITS;
	localparam int unsigned CTL_CUE       = CTRL_LSB + 0;
	localparam int unsigned CTL_IGNORE    = CTRL_LSB + 1;
	localparam int unsigned CTL_POWER     = CTRL_LSB + 2;
	localparam int unsigned CTL_PLAY      = CTRL_LSB + 3;
	localparam int unsigned CTL_RUN       = CTRL_LSB + 4;

	// status word shifted out while a frame comes in
	localparam int unsigned STAT_OVF      = 0;
	localparam int unsigned STAT_EOM      = 1;
	localparam int unsigned STAT_PTR_LSB  = 2;

	// memory array and row timing, counted in base ticks (twice the sample rate)
	localparam int unsigned ROWS          = 800;
	localparam int unsigned LAST_ROW      = ROWS - 1;
	localparam int unsigned ROW_US        = 150_000;
	localparam int unsigned ROW_BASE_TICKS = ROW_US / 1000 * SAMPLE_HZ * BASE_PER_SMP / 1000;
	localparam int unsigned CUE_SPEEDUP   = 800;
	localparam int unsigned CUE_ROW_TICKS = ROW_BASE_TICKS / CUE_SPEEDUP;
	localparam int unsigned ROW_LOW_DIV   = 12;
	localparam int unsigned ROW_LOW_TICKS = ROW_BASE_TICKS / ROW_LOW_DIV;
	localparam int unsigned CUE_LOW_TICKS = (CUE_ROW_TICKS / ROW_LOW_DIV > 0) ?
		CUE_ROW_TICKS / ROW_LOW_DIV : 1;
	localparam int unsigned PHASE_W       = $clog2(ROW_BASE_TICKS + 1);

	typedef enum logic [1:0] {PWR_OFF, PWR_WAKING, PWR_READY} power_t;
	typedef enum logic [1:0] {OP_IDLE, OP_PLAY, OP_CAPTURE, OP_SKIP} op_t;

endpackage

// file: pin_sync3.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk_i,    // system clock
	input  wire logic rstn_i,   // async reset, active low
	input  wire logic pin_i,    // asynchronous pin level
	output logic      stable_o  // filtered level in the clk_i domain
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// stage one is read by stage two only, to keep metastability contained
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// the level moves only when two settled stages agree
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stable_o <= RESET_VAL;
		end else if (s2_q == s3_q) begin
			stable_o <= s3_q;
		end
	end

endmodule // pin_sync3

// file: voice_store_spi_command.sv
// serial command interpreter and row sequencer of the voice store device
// Summary of operation
// - external sample clock divided by two internally
// - sample mosi on rising, change miso falling
// - frame holds five control, eleven address bits
// - end-of-message or overflow raises the interrupt
// - pending interrupt clears at next frame start
// - status shifts out while command shifts in
// - run bit one starts, zero ends operation
// - command takes effect when select rises
// - cueing runs 800x faster, stops past marker
// - power-up command, ready after wake delay
// - playback from row, runs to marker or overflow
// - capture from row until stopped or overflow
// - cueing from row to message end or overflow
// - power bit zero stops and powers down
// - stop code also returns the status flags
// - control bits: run, play, cue, power, address ignore
// - address ignore zero loads row and repeats it, else steps on
// - open-drain interrupt held low until cleared
// - overflow flag set at end of array
// - message end flag set only in playback or cueing
// - miso undriven while select is high
`timescale 1ns/1ps
module voice_store_spi_command #(
	parameter int unsigned WAKE_CYCLES  = voice_store_pkg::WAKE_CYCLES,
	parameter int unsigned INT_BASE_DIV = voice_store_pkg::INT_BASE_DIV,
	parameter int unsigned EXT_BASE_DIV = voice_store_pkg::EXT_BASE_DIV
) (
	input  wire logic                              clk_i,                   // 40 MHz clock
	input  wire logic                              rstn_i,                  // async reset, low
	input  wire logic                              ss_n_i,                  // slave select pin
	input  wire logic                              sclk_i,                  // serial clock pin
	input  wire logic                              mosi_i,                  // serial data in
	output logic                                   miso_o,                  // serial data out
	output logic                                   miso_oe_o,               // miso drive enable
	output logic                                   int_n_o,                 // interrupt level, low
	output logic                                   int_oe_o,                // interrupt pull-down
	output logic                                   row_boundary_pulse_n_o,  // row pulse, low
	output logic                                   row_boundary_pulse_oe_o, // row pulse pull-down
	input  wire logic                              external_sample_clock_i, // sample clock pin
	input  wire logic                              ext_clock_sel_i,         // use external clock
	output logic                                   power_control_o,         // array powered
	output logic                                   ready_o,                 // wake delay done
	output logic                                   op_active_o,             // operation running
	output logic                                   play_o,                  // playing or cueing
	output logic                                   cue_enable_o,            // cueing active
	output logic [voice_store_pkg::ROW_BITS-1:0]   row_pointer_out_o,       // current row
	output logic                                   memory_end_flag_o,       // overflow flag
	output logic                                   message_end_flag_o       // end-of-message flag
);
	import voice_store_pkg::*;

	localparam int unsigned WAKE_W = $clog2(WAKE_CYCLES + 1);
	localparam int unsigned IDIV_W = $clog2(INT_BASE_DIV + 1);
	localparam int unsigned EDIV_W = $clog2(EXT_BASE_DIV + 1);
	localparam int unsigned BCNT_W = $clog2(FRAME_BITS + 1);

	// refuse parameter values the counters cannot serve
	if (WAKE_CYCLES < 1 || INT_BASE_DIV < 2 || EXT_BASE_DIV < 1) begin : g_bad_param
		$error("voice_store_spi_command: parameter out of range");
	end

	logic ss_n_s;
	logic sclk_s;
	logic mosi_s;
	logic external_sample_clock_s;
	logic xsel_s;

	// every input pin but clock and reset crosses into the clock domain through three stages
	pin_sync3 #(.RESET_VAL(1'b1)) u_sync_ss (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.pin_i    (ss_n_i),
		.stable_o (ss_n_s)
	);
	pin_sync3 #(.RESET_VAL(1'b0)) u_sync_sclk (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.pin_i    (sclk_i),
		.stable_o (sclk_s)
	);
	pin_sync3 #(.RESET_VAL(1'b0)) u_sync_mosi (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.pin_i    (mosi_i),
		.stable_o (mosi_s)
	);
	pin_sync3 #(.RESET_VAL(1'b0)) u_sync_external_sample_clock (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.pin_i    (external_sample_clock_i),
		.stable_o (external_sample_clock_s)
	);
	pin_sync3 #(.RESET_VAL(1'b0)) u_sync_xsel (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.pin_i    (ext_clock_sel_i),
		.stable_o (xsel_s)
	);

	logic ss_prev_q;
	logic sclk_prev_q;
	logic external_sample_clock_prev_q;

	// previous levels for edge detection
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ss_prev_q   <= 1'b1;
			sclk_prev_q <= 1'b0;
			external_sample_clock_prev_q <= 1'b0;
		end else begin
			ss_prev_q   <= ss_n_s;
			sclk_prev_q <= sclk_s;
			external_sample_clock_prev_q <= external_sample_clock_s;
		end
	end

	logic frame_start;
	logic frame_end;
	logic sclk_rise;
	logic sclk_fall;

	assign frame_start = ss_prev_q & ~ss_n_s;
	assign frame_end   = ~ss_prev_q & ss_n_s;
	assign sclk_rise   = ~sclk_prev_q & sclk_s & ~ss_n_s;
	assign sclk_fall   = sclk_prev_q & ~sclk_s & ~ss_n_s;

	logic [FRAME_BITS-1:0] rx_q;
	logic [BCNT_W-1:0]     bit_cnt_q;

	// receive shifter: lsb first, so address lands low and control high
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_q      <= '0;
			bit_cnt_q <= '0;
		end else if (frame_start) begin
			bit_cnt_q <= '0;
		end else if (sclk_rise) begin
			rx_q <= {mosi_s, rx_q[FRAME_BITS-1:1]};
			if (bit_cnt_q != BCNT_W'(FRAME_BITS)) begin
				bit_cnt_q <= bit_cnt_q + 1'b1;
			end
		end
	end

	// a short frame is dropped rather than guessed at; a long one is taken with its last sixteen bits
	logic                cmd_ok;
	logic                c_run;
	logic                c_play;
	logic                c_cue;
	logic                c_power;
	logic                c_ignore;
	logic [ROW_BITS-1:0] c_addr;

	assign cmd_ok   = frame_end && (bit_cnt_q == BCNT_W'(FRAME_BITS));
	assign c_run    = rx_q[CTL_RUN];
	assign c_play   = rx_q[CTL_PLAY];
	assign c_cue    = rx_q[CTL_CUE];
	assign c_power  = rx_q[CTL_POWER];
	assign c_ignore = rx_q[CTL_IGNORE];
	assign c_addr   = rx_q[ADDR_LSB +: ROW_BITS]; // eleventh bit unused

	power_t            pwr_q;
	logic [WAKE_W-1:0] wake_cnt_q;

	// power state: off, waking for the wake delay, ready
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pwr_q      <= PWR_OFF;
			wake_cnt_q <= '0;
		end else if (cmd_ok && !c_power) begin
			pwr_q <= PWR_OFF;
		end else begin
			unique case (pwr_q)
				PWR_OFF: begin
					if (cmd_ok && c_power) begin
						pwr_q      <= PWR_WAKING;
						wake_cnt_q <= '0;
					end
				end
				PWR_WAKING: begin
					if (wake_cnt_q == WAKE_W'(WAKE_CYCLES - 1)) begin
						pwr_q <= PWR_READY;
					end else begin
						wake_cnt_q <= wake_cnt_q + 1'b1;
					end
				end
				PWR_READY: begin
					pwr_q <= PWR_READY;
				end
			endcase
		end
	end

	// base tick at twice the sample rate, from either clock source
	logic [IDIV_W-1:0] int_div_q;
	logic [EDIV_W-1:0] ext_div_q;
	logic              xdiv2_q;
	logic              int_tick;
	logic              ext_tick;
	logic              base_tick;
	logic              xdiv2_rise;

	assign xdiv2_rise = ~external_sample_clock_prev_q & external_sample_clock_s & ~xdiv2_q;
	assign int_tick   = (int_div_q == IDIV_W'(INT_BASE_DIV - 1));
	assign ext_tick   = xdiv2_rise && (ext_div_q == EDIV_W'(EXT_BASE_DIV - 1));
	assign base_tick  = xsel_s ? ext_tick : int_tick;

	// halving the pin clock first makes its duty cycle irrelevant
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xdiv2_q   <= 1'b0;
			ext_div_q <= '0;
		end else if (~external_sample_clock_prev_q & external_sample_clock_s) begin
			xdiv2_q <= ~xdiv2_q;
			if (xdiv2_rise) begin
				ext_div_q <= ext_tick ? '0 : ext_div_q + 1'b1;
			end
		end
	end

	// internal sample divider runs free
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			int_div_q <= '0;
		end else begin
			int_div_q <= int_tick ? '0 : int_div_q + 1'b1;
		end
	end

	// operation decode for a valid frame
	op_t op_q;
	op_t op_next_kind;
	logic start_op;
	logic stop_op;
	logic same_run;

	assign start_op = cmd_ok && c_power && c_run && (pwr_q == PWR_READY);
	assign stop_op  = cmd_ok && (!c_run || !c_power);
	// cueing is honoured only when playback is not already under way
	assign op_next_kind = !c_play ? OP_CAPTURE :
		((c_cue && op_q != OP_PLAY) ? OP_SKIP : OP_PLAY);
	assign same_run = (op_q == op_next_kind) && c_ignore;

	// row timing
	logic [PHASE_W-1:0]  phase_q;
	logic [PHASE_W-1:0]  row_len;
	logic [PHASE_W-1:0]  low_len;
	logic                row_end;
	logic [ROW_BITS-1:0] ptr_q;
	logic [ROWS-1:0]     mark_q;
	logic                at_last;
	logic                hit_mark;

	assign row_len  = (op_q == OP_SKIP) ? PHASE_W'(CUE_ROW_TICKS) : PHASE_W'(ROW_BASE_TICKS);
	assign low_len  = (op_q == OP_SKIP) ? PHASE_W'(CUE_LOW_TICKS) : PHASE_W'(ROW_LOW_TICKS);
	assign row_end  = (op_q != OP_IDLE) && base_tick && (phase_q == row_len - 1'b1);
	assign at_last  = (ptr_q >= ROW_BITS'(LAST_ROW));
	assign hit_mark = mark_q[ptr_q];

	// phase within the current row, restarted when a new row is loaded
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_q <= '0;
		end else if (start_op && !same_run) begin
			phase_q <= '0;
		end else if (row_end) begin
			phase_q <= '0;
		end else if (op_q != OP_IDLE && base_tick) begin
			phase_q <= phase_q + 1'b1;
		end
	end

	logic set_ovf;
	logic set_eom;
	logic capture_stop;

	// playback and cueing check the marker before the array end
	assign set_eom = row_end && (op_q == OP_PLAY || op_q == OP_SKIP) && hit_mark;
	assign set_ovf = row_end && at_last && !set_eom;
	assign capture_stop = (op_q == OP_CAPTURE) &&
		(stop_op || (start_op && op_next_kind != OP_CAPTURE) || set_ovf);

	// operation state
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			op_q <= OP_IDLE;
		end else if (stop_op) begin
			op_q <= OP_IDLE;
		end else if (start_op) begin
			op_q <= op_next_kind;
		end else if (set_eom || set_ovf) begin
			op_q <= OP_IDLE;
		end
	end

	// latest address-ignore setting; zero makes each row repeat
	logic c_ignore_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			c_ignore_q <= 1'b0;
		end else if (cmd_ok) begin
			c_ignore_q <= c_ignore;
		end
	end

	// row pointer: loaded from the frame, or stepped at a row end while address ignore is set or when a cue hits a marker
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr_q <= '0;
		end else if (start_op && !c_ignore) begin
			ptr_q <= c_addr;
		end else if (row_end) begin
			if (set_eom && op_q == OP_SKIP) begin
				ptr_q <= ptr_q + 1'b1; // next message
			end else if (!set_eom && !at_last && c_ignore_q) begin
				ptr_q <= ptr_q + 1'b1;
			end
		end
	end

	// message markers: capture marks the row where it stops,
	// and clears rows it runs past so stale markers do not survive
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mark_q <= '0;
		end else if (capture_stop) begin
			mark_q[ptr_q] <= 1'b1;
		end else if (row_end && op_q == OP_CAPTURE) begin
			mark_q[ptr_q] <= 1'b0;
		end
	end

	// sticky flags: an event in the frame-start cycle wins over the clear
	logic ovf_q;
	logic eom_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovf_q <= 1'b0;
		end else if (set_ovf) begin
			ovf_q <= 1'b1;
		end else if (frame_start) begin
			ovf_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			eom_q <= 1'b0;
		end else if (set_eom) begin
			eom_q <= 1'b1;
		end else if (frame_start) begin
			eom_q <= 1'b0;
		end
	end

	// transmit shifter: status is snapshot before the flags clear
	logic [FRAME_BITS-1:0] status_word;
	logic [FRAME_BITS-1:0] tx_q;
	logic                  miso_q;

	always_comb begin
		status_word                            = '0;
		status_word[STAT_OVF]                  = ovf_q;
		status_word[STAT_EOM]                  = eom_q;
		status_word[STAT_PTR_LSB +: ROW_BITS]  = ptr_q;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_q   <= '0;
			miso_q <= 1'b0;
		end else if (frame_start) begin
			miso_q <= status_word[0];
			tx_q   <= {1'b0, status_word[FRAME_BITS-1:1]};
		end else if (sclk_fall) begin
			miso_q <= tx_q[0];
			tx_q   <= {1'b0, tx_q[FRAME_BITS-1:1]};
		end
	end

	// row boundary pulse goes low for the last twelfth of each row, and for the last of its three ticks when cueing
	logic rac_low_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rac_low_q <= 1'b0;
		end else begin
			rac_low_q <= (op_q != OP_IDLE) && (phase_q >= row_len - low_len);
		end
	end

	// open-drain pins only ever pull low
	assign miso_o                  = miso_q;
	assign miso_oe_o               = ~ss_n_s;
	assign int_n_o                 = 1'b0;
	assign int_oe_o                = ovf_q | eom_q;
	assign row_boundary_pulse_n_o  = 1'b0;
	assign row_boundary_pulse_oe_o = rac_low_q;

	// status outputs straight from state flops
	assign power_control_o    = (pwr_q != PWR_OFF);
	assign ready_o            = (pwr_q == PWR_READY);
	assign op_active_o        = (op_q != OP_IDLE);
	assign play_o             = (op_q == OP_PLAY) || (op_q == OP_SKIP);
	assign cue_enable_o       = (op_q == OP_SKIP);
	assign row_pointer_out_o  = ptr_q;
	assign memory_end_flag_o  = ovf_q;
	assign message_end_flag_o = eom_q;

endmodule // voice_store_spi_command

// file: voice_store_monitor.sv
// assertion checker of the voice store command block, bound to its ports
`timescale 1ns/1ps
module voice_store_monitor #(
	parameter int unsigned WAKE_CYCLES = 20
) (
	input wire logic                            clk_i,              // clock
	input wire logic                            rstn_i,             // reset, low
	input wire logic                            ss_n_i,             // select pin
	input wire logic                            miso_oe_o,          // miso enable
	input wire logic                            int_n_o,            // interrupt level
	input wire logic                            int_oe_o,           // interrupt pull
	input wire logic                            power_control_o,    // powered
	input wire logic                            ready_o,            // awake
	input wire logic                            op_active_o,        // running
	input wire logic                            play_o,             // playing
	input wire logic                            cue_enable_o,       // cueing
	input wire logic [voice_store_pkg::ROW_BITS-1:0] row_pointer_out_o, // row
	input wire logic                            memory_end_flag_o,  // overflow
	input wire logic                            message_end_flag_o  // message end
);
	import voice_store_pkg::*;
	logic [31:0] wake_q;
	logic        flag;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// cycles spent waking; cleared when off so a second power-up is not counted
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) wake_q <= '0;
		else if (!power_control_o || ready_o) wake_q <= '0;
		else wake_q <= wake_q + 32'h1;
	end
	assign flag = memory_end_flag_o || message_end_flag_o;
	// port relations
	miso_hiz_a: assert property (ss_n_i [*6] |-> !miso_oe_o)
		else $error("miso driven while deselected");
	miso_on_a: assert property ($fell(ss_n_i) |-> ##[2:8] miso_oe_o)
		else $error("miso not driven in frame");
	int_clear_a: assert property ($fell(ss_n_i) |-> ##[2:8] !int_oe_o)
		else $error("interrupt not cleared at frame start");
	int_flag_a: assert property (flag |-> ##[0:1] (int_oe_o && !int_n_o))
		else $error("interrupt not pulled with flag set");
	pwr_hold_a: assert property (!ss_n_i [*6] |-> $stable(power_control_o))
		else $error("power changed inside frame");
	wake_len_a: assert property ($rose(ready_o) |-> wake_q >= WAKE_CYCLES - 2 &&
		wake_q <= WAKE_CYCLES + 2)
		else $error("wake delay length wrong");
	ready_pwr_a: assert property (ready_o |-> power_control_o)
		else $error("ready while unpowered");
	down_idle_a: assert property (!power_control_o |-> !op_active_o)
		else $error("operation while powered down");
	cue_play_a: assert property (cue_enable_o |-> play_o && op_active_o)
		else $error("cueing outside playback");
	flag_stop_a: assert property ($rose(flag) |-> ##[0:2] !op_active_o)
		else $error("operation runs on after flag");
	eom_play_a: assert property ($rose(message_end_flag_o) |->
		$past(play_o) || $past(play_o, 2))
		else $error("message end outside playback");
	row_max_a: assert property (row_pointer_out_o <= LAST_ROW)
		else $error("row pointer past array");
	// main scenarios
	ovf_c: cover property ($rose(memory_end_flag_o));
	eom_c: cover property ($rose(message_end_flag_o));
	cue_c: cover property ($rose(cue_enable_o));
endmodule // voice_store_monitor

bind voice_store_spi_command voice_store_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_mon (
	.clk_i, .rstn_i, .ss_n_i, .miso_oe_o, .int_n_o, .int_oe_o, .power_control_o,
	.ready_o, .op_active_o, .play_o, .cue_enable_o, .row_pointer_out_o,
	.memory_end_flag_o, .message_end_flag_o);

// file: voice_store_host.sv
// serial master model that frames commands and collects the status word
`timescale 1ns/1ps
module voice_store_host (
	input  wire logic clk_i,  // system clock
	input  wire logic miso_i, // device data, z when released
	output logic      ss_n_o, // select, low in frame
	output logic      sclk_o, // serial clock, idle low
	output logic      mosi_o  // data to device
);
	localparam int HALF = 8; // sclk half period in clk, above the sync limit
	initial begin
		ss_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// one whole frame, lsb first, address field before control bits
	task automatic xfer(input logic [15:0] cmd, output logic [15:0] stat);
		ss_n_o = 1'b0;
		tick(HALF);
		for (int i = 0; i < 16; i++) begin
			mosi_o = cmd[i];
			tick(HALF);
			sclk_o = 1'b1;
			stat[i] = miso_i;
			tick(HALF);
			sclk_o = 1'b0;
		end
		tick(HALF);
		ss_n_o = 1'b1;
		mosi_o = ~mosi_o; // no stale bit left on the line
		tick(HALF);
	endtask
endmodule // voice_store_host

// file: voice_store_spi_command_bench.sv
// self-checking bench of the voice store command block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module voice_store_spi_command_bench;
	import voice_store_pkg::*;
	localparam int unsigned WAKE = 20; // short wake delay for simulation
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic ss_n_i, sclk_i, mosi_i, miso_o, miso_oe_o, int_n_o, int_oe_o;
	logic row_boundary_pulse_n_o, row_boundary_pulse_oe_o;
	logic power_control_o, ready_o, op_active_o, play_o, cue_enable_o;
	logic memory_end_flag_o, message_end_flag_o;
	logic [ROW_BITS-1:0] row_pointer_out_o;
	logic [15:0] st;
	logic external_sample_clock_i = 1'h0; // lopsided sample clock, made below
	logic ext_clock_sel_i = 1'h0;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	wire miso_w = miso_oe_o ? miso_o : 1'bz;
	always #12.5 clk_i = ~clk_i;
	voice_store_spi_command #(.WAKE_CYCLES(WAKE), .INT_BASE_DIV(4), .EXT_BASE_DIV(1)) dut (
		.clk_i, .rstn_i, .ss_n_i, .sclk_i, .mosi_i, .miso_o, .miso_oe_o, .int_n_o,
		.int_oe_o, .row_boundary_pulse_n_o, .row_boundary_pulse_oe_o,
		.external_sample_clock_i, .ext_clock_sel_i, .power_control_o, .ready_o,
		.op_active_o, .play_o, .cue_enable_o, .row_pointer_out_o,
		.memory_end_flag_o, .message_end_flag_o);
	voice_store_host host (.clk_i, .miso_i(miso_w), .ss_n_o(ss_n_i), .sclk_o(sclk_i),
		.mosi_o(mosi_i));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// one third duty on purpose: the halving inside must hide it
	always begin
		tick(8);
		external_sample_clock_i = 1'h1; // stands in for the scaled required rate
		tick(4);
		external_sample_clock_i = 1'h0;
	end
	// bounded wait for the running operation to end
	task automatic wait_idle(input int lim);
		int n;
		n = 0;
		while (op_active_o !== 1'h0 && n < lim) begin
			tick(1);
			n++;
		end
		`CHK(op_active_o, 1'h0);
	endtask
	task automatic results();
		$display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_reset();
		`CHK({miso_oe_o, int_oe_o, power_control_o, ready_o, op_active_o}, 5'h00);
		`CHK(row_pointer_out_o, 10'h000);
	endtask
	// playback asked while unpowered must be dropped
	task automatic t_refuse();
		host.xfer(16'hE000, st);
		`CHK(op_active_o, 1'h0);
		`CHK(st, 16'h0000);
		host.xfer(16'h0000, st); // the power bit began a wake, undo it
		`CHK(power_control_o, 1'h0);
	endtask
	// power-up sequence with two power-ups
	task automatic t_wake();
		host.xfer(16'h2000, st);
		`CHK({power_control_o, ready_o}, 2'h2);
		tick(WAKE);
		`CHK(ready_o, 1'h1);
		host.xfer(16'h2000, st);
		tick(2 * WAKE);
	endtask
	// capture at row 5, stopped at once so the row holds a marker
	task automatic t_capture();
		host.xfer(16'hA005, st);
		`CHK({op_active_o, play_o, cue_enable_o}, 3'h4);
		`CHK(row_pointer_out_o, 10'h005);
		host.xfer(16'h3000, st);
		`CHK(op_active_o, 1'h0);
		`CHK(st, 16'h0014);
	endtask
	// cue from row 3 stops on the row 5 marker, pointing past it
	task automatic t_cue();
		host.xfer(16'hE803, st); // cueing chosen as the run starts
		`CHK(cue_enable_o, 1'h1);
		tick(40);
		`CHK(row_pointer_out_o, 10'h003); // row repeats while ignore is low
		host.xfer(16'hF800, st);
		wait_idle(400);
		`CHK(row_pointer_out_o, 10'h006);
		`CHK(int_oe_o, 1'h1);
	endtask
	// status read with a don't-care bit set, flags cleared by the frame
	task automatic t_status();
		host.xfer(16'h7000, st);
		`CHK(st, 16'h001A);
		`CHK({int_oe_o, message_end_flag_o}, 2'h0);
	endtask
	// playback from row 5 with reserved address bit set hits the marker
	task automatic t_play();
		host.xfer(16'hE405, st);
		`CHK({op_active_o, play_o, row_pointer_out_o}, {2'h3, 10'h005});
		`CHK({row_boundary_pulse_oe_o, row_boundary_pulse_n_o, int_n_o}, 3'h0);
		tick(9000);
		`CHK(row_boundary_pulse_oe_o, 1'h1); // last twelfth of the row
		wait_idle(12000);
		`CHK({message_end_flag_o, memory_end_flag_o}, 2'h2);
		`CHK(row_pointer_out_o, 10'h005);
	endtask
	// cue near the end of the array runs into overflow
	task automatic t_overflow();
		host.xfer(16'hEB1D, st);
		`CHK(st, 16'h0016);
		host.xfer(16'hF800, st);
		wait_idle(400);
		`CHK({memory_end_flag_o, message_end_flag_o}, 2'h2);
		`CHK(int_oe_o, 1'h1);
	endtask
	// same cue on the external clock: rows take far longer than on the internal one
	task automatic t_ext();
		ext_clock_sel_i = 1'h1;
		host.xfer(16'hEB1D, st);
		`CHK(st, 16'h0C7D);
		host.xfer(16'hF800, st);
		tick(100);
		`CHK(op_active_o, 1'h1);
		wait_idle(600);
		`CHK(memory_end_flag_o, 1'h1);
	endtask
	// capture then stop with power-down, don't-care bits set
	task automatic t_down();
		host.xfer(16'hA000, st);
		`CHK(st[1:0], 2'h1);
		`CHK({op_active_o, play_o}, 2'h2);
		host.xfer(16'h5800, st);
		`CHK({power_control_o, ready_o, op_active_o}, 3'h0);
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			results();
		end
	end
	// main sequence
	initial begin
		tick(4);
		rstn_i = 1'h1;
		tick(4);
		t_reset();
		t_refuse();
		t_wake();
		t_capture();
		t_cue();
		t_status();
		t_play();
		t_overflow();
		t_ext();
		t_down();
		results();
	end
endmodule // voice_store_spi_command_bench
